// file: logic/mcd_dma_ctrl.sv
// Purpose: multi-channel DMA engine with an AXI4-Lite register port
// Assumes: mem_rdata_in is valid in the cycle that mem_req_out.rd is high
// Notes: fixed priority, lowest channel first; a block keeps the bus
`timescale 1ns/10ps
module mcd_dma_ctrl
#(
    parameter int NUM_CH = mcd_pkg::CH_NUM
)
(
    input  wire logic                 clk_in,
    input  wire logic                 rstn_in,
    input  wire logic [31:0]          s_axi_awaddr_in,
    input  wire logic                 s_axi_awvalid_in,
    output logic                      s_axi_awready_out,
    input  wire logic [31:0]          s_axi_wdata_in,
    input  wire logic [3:0]           s_axi_wstrb_in,
    input  wire logic                 s_axi_wvalid_in,
    output logic                      s_axi_wready_out,
    output logic [1:0]                s_axi_bresp_out,
    output logic                      s_axi_bvalid_out,
    input  wire logic                 s_axi_bready_in,
    input  wire logic [31:0]          s_axi_araddr_in,
    input  wire logic                 s_axi_arvalid_in,
    output logic                      s_axi_arready_out,
    output logic [31:0]               s_axi_rdata_out,
    output logic [1:0]                s_axi_rresp_out,
    output logic                      s_axi_rvalid_out,
    input  wire logic                 s_axi_rready_in,
    input  wire logic [NUM_CH-1:0]    trig_in,
    output mcd_pkg::mcd_mem_req_t     mem_req_out,
    input  wire logic [15:0]          mem_rdata_in,
    output logic                      cpu_halt_out
);
    localparam int CW = mcd_pkg::CUR_W;

    typedef struct packed {
        mcd_pkg::mcd_chan_t [NUM_CH-1:0] ch;
        mcd_pkg::mcd_phase_t             ph;
        logic [CW-1:0]                   cur;
        logic [1:0]                      bcnt;
        logic                            gap;
        logic                            halt;
        mcd_pkg::mcd_mem_req_t           mem;
        logic [NUM_CH-1:0]               t1;
        logic [NUM_CH-1:0]               t2;
        logic [NUM_CH-1:0]               t3;
        logic [NUM_CH-1:0]               tst;
        logic                            awgot;
        logic                            wgot;
        logic [31:0]                     awa;
        logic [31:0]                     wd;
        logic [3:0]                      ws;
        logic                            awrdy;
        logic                            wrdy;
        logic                            bvalid;
        logic [1:0]                      bresp;
        logic                            arrdy;
        logic                            rvalid;
        logic [1:0]                      rresp;
        logic [31:0]                     rdata;
    } mcd_state_t;

    mcd_state_t         r_reg;
    mcd_state_t         r_next;
    logic [NUM_CH-1:0]  rdy;
    logic [NUM_CH-1:0]  rise;
    mcd_pkg::mcd_chan_t cc;
    logic               fin;

    function automatic logic [mcd_pkg::ADDR_W-1:0] step_addr(
        input logic [mcd_pkg::ADDR_W-1:0] a,
        input logic [1:0]                 sel,
        input logic                       byte_unit
    );
        logic [mcd_pkg::ADDR_W-1:0] d;
        d = byte_unit ? mcd_pkg::STEP_BYTE : mcd_pkg::STEP_WORD;
        if (sel == mcd_pkg::STEP_INC)
            return a + d;
        else if (sel == mcd_pkg::STEP_DEC)
            return a - d;
        return a;
    endfunction

    function automatic logic [31:0] ctrl_word(input mcd_pkg::mcd_chan_t c);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[mcd_pkg::F_MODE +: 3]  = c.mode;
        v[mcd_pkg::F_DSTEP +: 2] = c.dstep;
        v[mcd_pkg::F_SSTEP +: 2] = c.sstep;
        v[mcd_pkg::F_DBYTE]      = c.dbyte;
        v[mcd_pkg::F_SBYTE]      = c.sbyte;
        v[mcd_pkg::F_LVL]        = c.lvl;
        v[mcd_pkg::F_ARM]        = c.arm;
        v[mcd_pkg::F_DONE]       = c.done;
        v[mcd_pkg::F_BUSY]       = c.act | c.pend;
        return v;
    endfunction

    // Upper bit is the hit flag, lower word the register value
    function automatic logic [32:0] reg_read(
        input mcd_state_t  s,
        input logic [31:0] a
    );
        mcd_pkg::mcd_chan_t c;
        logic [32:0]        res;
        c = s.ch[a[mcd_pkg::CH_SHIFT +: CW]];
        res = 33'h0_0000_0000;
        if (a[31:8] == 24'h00_0000 && a[7:4] < NUM_CH)
        begin
            if (a[3:0] == mcd_pkg::REG_CTRL)
                res = {1'b1, ctrl_word(c)};
            else if (a[3:0] == mcd_pkg::REG_SRC)
                res = {1'b1, 12'h000, c.src_s};
            else if (a[3:0] == mcd_pkg::REG_DST)
                res = {1'b1, 12'h000, c.dst_s};
            else if (a[3:0] == mcd_pkg::REG_CNT)
                res = {1'b1, 16'h0000, c.cnt_w};
        end
        return res;
    endfunction

    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
        assign rise[g] = r_reg.t2[g] & r_reg.t3[g] & ~r_reg.tst[g];
        assign rdy[g] = r_reg.ch[g].arm && r_reg.ch[g].cnt_s != '0
                     && (r_reg.ch[g].lvl ? r_reg.tst[g]
                                         : (r_reg.ch[g].pend | r_reg.ch[g].act));
    end

    assign cc  = r_reg.ch[r_reg.cur];
    assign fin = r_reg.ph == mcd_pkg::ST_WR && cc.cnt_w == mcd_pkg::CNT_ONE;

    always_comb
    begin
        logic [32:0]        rv;
        logic [31:0]        v;
        logic [CW-1:0]      wi;
        logic [CW-1:0]      sel;
        logic               found;
        logic               cont;
        mcd_pkg::mcd_chan_t c;
        rv     = '0;
        v      = '0;
        wi     = '0;
        sel    = '0;
        found  = 1'b0;
        cont   = 1'b0;
        c      = '0;
        r_next = r_reg;
        // Three-stage synchroniser; a level counts once stages 2 and 3 agree
        r_next.t1 = trig_in;
        r_next.t2 = r_reg.t1;
        r_next.t3 = r_reg.t2;
        for (int k = 0; k < NUM_CH; k++)
            if (r_reg.t2[k] == r_reg.t3[k])
                r_next.tst[k] = r_reg.t3[k];

        // Register write side: address and data may come in either order
        if (r_reg.awrdy && s_axi_awvalid_in)
        begin
            r_next.awgot = 1'b1;
            r_next.awa   = s_axi_awaddr_in;
        end
        if (r_reg.wrdy && s_axi_wvalid_in)
        begin
            r_next.wgot = 1'b1;
            r_next.wd   = s_axi_wdata_in;
            r_next.ws   = s_axi_wstrb_in;
        end
        if (r_reg.bvalid && s_axi_bready_in)
            r_next.bvalid = 1'b0;
        if (r_reg.awgot && r_reg.wgot && !r_reg.bvalid)
        begin
            rv = reg_read(r_reg, r_reg.awa);
            for (int b = 0; b < 4; b++)
                v[8*b +: 8] = r_reg.ws[b] ? r_reg.wd[8*b +: 8] : rv[8*b +: 8];
            wi = r_reg.awa[mcd_pkg::CH_SHIFT +: CW];
            c  = r_next.ch[wi];
            if (rv[32] && r_reg.awa[3:0] == mcd_pkg::REG_CTRL)
            begin
                c.mode  = v[mcd_pkg::F_MODE +: 3];
                c.dstep = v[mcd_pkg::F_DSTEP +: 2];
                c.sstep = v[mcd_pkg::F_SSTEP +: 2];
                c.dbyte = v[mcd_pkg::F_DBYTE];
                c.sbyte = v[mcd_pkg::F_SBYTE];
                c.lvl   = v[mcd_pkg::F_LVL];
                c.done  = v[mcd_pkg::F_DONE];
                c.arm   = v[mcd_pkg::F_ARM];
                if (v[mcd_pkg::F_ARM] && !r_reg.ch[wi].arm)
                begin
                    c.src_w = c.src_s;
                    c.dst_w = c.dst_s;
                    c.cnt_w = c.cnt_s;
                end
                if (!c.arm || !r_reg.ch[wi].arm)
                begin
                    c.act  = 1'b0;
                    c.pend = 1'b0;
                end
            end
            else if (rv[32] && r_reg.awa[3:0] == mcd_pkg::REG_SRC)
                c.src_s = v[mcd_pkg::ADDR_W-1:0];
            else if (rv[32] && r_reg.awa[3:0] == mcd_pkg::REG_DST)
                c.dst_s = v[mcd_pkg::ADDR_W-1:0];
            else if (rv[32])
                c.cnt_s = v[mcd_pkg::CNT_W-1:0];
            if (rv[32])
                r_next.ch[wi] = c;
            r_next.awgot  = 1'b0;
            r_next.wgot   = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp  = rv[32] ? mcd_pkg::RESP_OKAY : mcd_pkg::RESP_SLVERR;
        end
        r_next.awrdy = !r_next.awgot && !r_next.bvalid;
        r_next.wrdy  = !r_next.wgot && !r_next.bvalid;

        // Register read side
        if (r_reg.rvalid && s_axi_rready_in)
            r_next.rvalid = 1'b0;
        if (r_reg.arrdy && s_axi_arvalid_in)
        begin
            rv            = reg_read(r_reg, s_axi_araddr_in);
            r_next.rvalid = 1'b1;
            r_next.rdata  = rv[31:0];
            r_next.rresp  = rv[32] ? mcd_pkg::RESP_OKAY : mcd_pkg::RESP_SLVERR;
        end
        r_next.arrdy = !r_next.rvalid;

        for (int k = 0; k < NUM_CH; k++)
            if (rise[k] && !r_reg.ch[k].lvl && r_next.ch[k].arm
                && r_next.ch[k].cnt_s != '0)
            begin
                if (r_next.ch[k].mode[1:0] != 2'h0)
                    r_next.ch[k].act = 1'b1;
                else
                    r_next.ch[k].pend = 1'b1;
            end

        case (r_reg.ph)
            mcd_pkg::ST_IDLE:
            begin
                for (int k = NUM_CH - 1; k >= 0; k--)
                    if (rdy[k])
                    begin
                        found = 1'b1;
                        sel   = k[CW-1:0];
                    end
                if (found)
                begin
                    r_next.cur           = sel;
                    r_next.bcnt          = 2'h0;
                    r_next.ph            = mcd_pkg::ST_RD;
                    r_next.mem.addr      = r_reg.ch[sel].src_w;
                    r_next.mem.rd        = 1'b1;
                    r_next.mem.byte_unit = r_reg.ch[sel].sbyte;
                end
            end
            mcd_pkg::ST_RD:
            begin
                r_next.ph            = mcd_pkg::ST_WR;
                r_next.mem.rd        = 1'b0;
                r_next.mem.wr        = 1'b1;
                r_next.mem.addr      = cc.dst_w;
                r_next.mem.byte_unit = cc.dbyte;
                r_next.mem.wdata = (cc.sbyte || cc.dbyte)
                                 ? {8'h00, mem_rdata_in[7:0]} : mem_rdata_in;
            end
            mcd_pkg::ST_WR:
            begin
                r_next.mem.wr = 1'b0;
                c = r_next.ch[r_reg.cur];
                c.src_w = step_addr(cc.src_w, cc.sstep, cc.sbyte);
                c.dst_w = step_addr(cc.dst_w, cc.dstep, cc.dbyte);
                c.pend  = 1'b0;
                if (fin)
                begin
                    c.cnt_w     = c.cnt_s;
                    c.done      = 1'b1;
                    r_next.bcnt = 2'h0;
                    if (!cc.mode[mcd_pkg::MODE_REP_BIT])
                        c.arm = 1'b0;
                    c.act = cc.mode[mcd_pkg::MODE_REP_BIT]
                          & cc.mode[mcd_pkg::MODE_BURST_BIT];
                end
                else
                begin
                    c.cnt_w     = cc.cnt_w - mcd_pkg::CNT_ONE;
                    r_next.bcnt = r_reg.bcnt + 2'h1;
                end
                r_next.ch[r_reg.cur] = c;
                // A block keeps the bus; level mode holds while the line is high
                cont = c.arm && cc.mode[1:0] != 2'h0 && (!fin || c.act)
                    && (cc.lvl ? r_reg.tst[r_reg.cur] : 1'b1);
                if (cont && cc.mode[mcd_pkg::MODE_BURST_BIT] && !fin
                    && r_reg.bcnt == mcd_pkg::BURST_LAST)
                begin
                    r_next.ph  = mcd_pkg::ST_GAP;
                    r_next.gap = 1'b0;
                end
                else if (cont)
                begin
                    r_next.ph            = mcd_pkg::ST_RD;
                    r_next.mem.addr      = c.src_w;
                    r_next.mem.rd        = 1'b1;
                    r_next.mem.byte_unit = cc.sbyte;
                end
                else
                    r_next.ph = mcd_pkg::ST_IDLE;
            end
            mcd_pkg::ST_GAP:
            begin
                r_next.gap = ~r_reg.gap;
                if (r_reg.gap && rdy[r_reg.cur])
                begin
                    r_next.ph            = mcd_pkg::ST_RD;
                    r_next.mem.addr      = cc.src_w;
                    r_next.mem.rd        = 1'b1;
                    r_next.mem.byte_unit = cc.sbyte;
                end
                else if (r_reg.gap)
                    r_next.ph = mcd_pkg::ST_IDLE;
            end
            default:
                r_next.ph = mcd_pkg::ST_IDLE;
        endcase
        r_next.halt = r_next.ph == mcd_pkg::ST_RD
                   || r_next.ph == mcd_pkg::ST_WR;
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign s_axi_awready_out = r_reg.awrdy;
    assign s_axi_wready_out  = r_reg.wrdy;
    assign s_axi_bvalid_out  = r_reg.bvalid;
    assign s_axi_bresp_out   = r_reg.bresp;
    assign s_axi_arready_out = r_reg.arrdy;
    assign s_axi_rvalid_out  = r_reg.rvalid;
    assign s_axi_rdata_out   = r_reg.rdata;
    assign s_axi_rresp_out   = r_reg.rresp;
    assign mem_req_out       = r_reg.mem;
    assign cpu_halt_out      = r_reg.halt;

    // Checks
    logic [mcd_pkg::ADDR_W-1:0] src_exp;
    logic [mcd_pkg::ADDR_W-1:0] dst_exp;
    assign src_exp = cc.src_w
                   + (cc.sbyte ? mcd_pkg::STEP_BYTE : mcd_pkg::STEP_WORD);
    assign dst_exp = cc.dst_w
                   - (cc.dbyte ? mcd_pkg::STEP_BYTE : mcd_pkg::STEP_WORD);

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    chk_rd_then_wr: assert property (
        mem_req_out.rd |=> mem_req_out.wr && !mem_req_out.rd ##1 !mem_req_out.wr)
        else $error("read not followed by one write cycle");
    chk_src_incr: assert property (
        r_reg.ph == mcd_pkg::ST_WR && cc.sstep == mcd_pkg::STEP_INC
        |=> cc.src_w == $past(src_exp))
        else $error("source address did not step up");
    chk_dst_decr: assert property (
        r_reg.ph == mcd_pkg::ST_WR && cc.dstep == mcd_pkg::STEP_DEC
        |=> cc.dst_w == $past(dst_exp))
        else $error("destination address did not step down");
    chk_word_to_byte: assert property (
        mem_req_out.wr && cc.dbyte
        |-> mem_req_out.byte_unit && mem_req_out.wdata[15:8] == 8'h00)
        else $error("byte destination got more than the low byte");
    chk_byte_to_word: assert property (
        mem_req_out.wr && cc.sbyte && !cc.dbyte
        |-> !mem_req_out.byte_unit && mem_req_out.wdata[15:8] == 8'h00)
        else $error("word destination upper byte not cleared");
    chk_single_disarm: assert property (
        fin && cc.mode == mcd_pkg::MODE_SINGLE |=> !cc.arm)
        else $error("single mode stayed armed after the count");
    chk_block_runs: assert property (
        r_reg.ph == mcd_pkg::ST_WR && cc.mode == mcd_pkg::MODE_BLOCK
        && !fin && !cc.lvl && cc.arm |=> r_reg.ph == mcd_pkg::ST_RD)
        else $error("block did not continue without a trigger");
    chk_repeat_armed: assert property (
        fin && cc.mode[mcd_pkg::MODE_REP_BIT] && cc.arm |=> cc.arm)
        else $error("repeated mode disarmed");
    chk_zero_count: assert property (
        r_reg.ph == mcd_pkg::ST_RD |-> cc.cnt_s != '0)
        else $error("transfer with zero count");
    chk_done_reload: assert property (
        fin |=> cc.done && cc.cnt_w == cc.cnt_s)
        else $error("count not reloaded or done not set");
    chk_burst_gap: assert property (
        r_reg.ph == mcd_pkg::ST_WR && cc.mode[mcd_pkg::MODE_BURST_BIT]
        && r_reg.bcnt == mcd_pkg::BURST_LAST && !fin && !cc.lvl && cc.arm
        |=> !cpu_halt_out [*2])
        else $error("burst gap missing");

    cov_single_done: cover property (fin && cc.mode == mcd_pkg::MODE_SINGLE);
    cov_burst_gap: cover property (
        r_reg.ph == mcd_pkg::ST_GAP ##1 r_reg.ph == mcd_pkg::ST_GAP
        ##1 r_reg.ph == mcd_pkg::ST_RD);
    cov_byte_to_word: cover property (mem_req_out.wr && cc.sbyte && !cc.dbyte);
    cov_rep_burst: cover property (
        fin && cc.mode[mcd_pkg::MODE_REP_BIT] && cc.mode[mcd_pkg::MODE_BURST_BIT]
        ##1 r_reg.ph == mcd_pkg::ST_RD);
endmodule

// file: shared/mcd_pkg.sv
// Purpose: constants and types of the multi-channel DMA controller
// Assumes: AXI4-Lite register port, 16-bit system data bus
// Notes: each channel owns a 16-byte block of four registers
// How it works
// - Up to three channels, each with its own modes and widths
// - One unit moves in two cycles: read source, then write destination
// - Transfer count is 16 bits, up to 65535 units per arming
// - Source address steps up, down or holds after each unit
// - Destination address steps up, down or holds after each unit
// - Word source to byte destination writes only bits 7 to 0
// - Byte source to word destination zeroes the upper byte
// - Source and destination width are chosen separately
// - Mode 000 moves one unit per trigger, disarms after the count
// - Mode 001 moves a whole block per trigger, then disarms
// - Modes 010 and 011 interleave the block with processor time
// - Modes 100 to 111 repeat those behaviours and stay armed
// - Any transfer mode works with any addressing mode
// - Addresses may point anywhere in the system address space
// - A zero count means triggers move nothing
// - At count zero the count reloads and the done flag sets
// - Burst blocks give the processor two cycles every four units
// - Edge mode starts on a rising trigger edge
package mcd_pkg;
    localparam int CH_NUM   = 3;
    localparam int ADDR_W   = 20;
    localparam int CNT_W    = 16;
    localparam int CUR_W    = 2;
    localparam int CH_SHIFT = 4;
    // Register offsets inside one channel block
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_SRC  = 4'h4;
    localparam logic [3:0] REG_DST  = 4'h8;
    localparam logic [3:0] REG_CNT  = 4'hC;
    // Control word field positions
    localparam int F_MODE  = 0;
    localparam int F_DSTEP = 3;
    localparam int F_SSTEP = 5;
    localparam int F_DBYTE = 7;
    localparam int F_SBYTE = 8;
    localparam int F_LVL   = 9;
    localparam int F_ARM   = 10;
    localparam int F_DONE  = 11;
    localparam int F_BUSY  = 12;
    localparam logic [1:0] STEP_DEC = 2'h2;
    localparam logic [1:0] STEP_INC = 2'h3;
    localparam logic [ADDR_W-1:0] STEP_BYTE = 20'h0_0001;
    localparam logic [ADDR_W-1:0] STEP_WORD = 20'h0_0002;
    localparam logic [2:0] MODE_SINGLE = 3'h0;
    localparam logic [2:0] MODE_BLOCK  = 3'h1;
    localparam int MODE_REP_BIT   = 2;
    localparam int MODE_BURST_BIT = 1;
    // Fourth unit of a burst, after which the gap follows
    localparam logic [1:0] BURST_LAST = 2'h3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR, ST_GAP} mcd_phase_t;

    typedef struct packed {
        logic [2:0]        mode;
        logic [1:0]        sstep;
        logic [1:0]        dstep;
        logic              sbyte;
        logic              dbyte;
        logic              lvl;
        logic              arm;
        logic              done;
        logic              act;
        logic              pend;
        logic [ADDR_W-1:0] src_s;
        logic [ADDR_W-1:0] dst_s;
        logic [ADDR_W-1:0] src_w;
        logic [ADDR_W-1:0] dst_w;
        logic [CNT_W-1:0]  cnt_s;
        logic [CNT_W-1:0]  cnt_w;
    } mcd_chan_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              rd;
        logic              wr;
        logic              byte_unit;
        logic [15:0]       wdata;
    } mcd_mem_req_t;
endpackage

// file: tb/mcd_dma_ctrl_tb.sv
// Purpose: register-driven transfer tests of the DMA engine
// Assumes: bready and rready held high, a legal master habit
// Notes: memory word k starts as 16'hA000 plus k
`timescale 1ns/10ps
module mcd_dma_ctrl_tb;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000;
    logic [31:0] araddr = 32'h0000_0000, rd_v, rdata_o;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, rdy = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, halt;
    logic [1:0] bresp, rresp, rs_v, bs_v;
    logic [2:0] trig = 3'h0;
    logic [15:0] mrd;
    mcd_pkg::mcd_mem_req_t req;
    int error_cnt = 0, n_checks = 0, cyc = 0, hcnt = 0, c0 = 0, c1 = 0;
    initial forever #5 clk_in = ~clk_in;
    mcd_dma_ctrl DUT (.clk_in(clk_in), .rstn_in(rstn_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(rdy),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata_o),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rdy), .trig_in(trig), .mem_req_out(req),
        .mem_rdata_in(mrd), .cpu_halt_out(halt));
    mcd_mem_model mem_i (.clk_in(clk_in), .req_in(req), .rdata_out(mrd));
    task automatic close_out;
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Halt span and cycle count; limit cuts a hang short
    // Counted off the falling edge so halt is read settled
    always @(negedge clk_in)
    begin
        cyc++;
        if (halt === 1'b1)
        begin
            if (hcnt == 0) c0 = cyc;
            c1 = cyc;
            hcnt++;
        end
        if (cyc == 20000)
        begin
            error_cnt++;
            close_out;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chm(input int i, input logic [15:0] exp);
        chk(32'(mem_i.mem[i]), 32'(exp));
    endtask
    // Ready and valid are read mid-cycle, where they stand for the next edge
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic aw_t;
        logic w_t;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(negedge clk_in);
            aw_t = awvalid && awready === 1'b1;
            w_t = wvalid && wready === 1'b1;
            @(posedge clk_in);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
        end while ((awvalid && !aw_t) || (wvalid && !w_t));
        do @(negedge clk_in); while (bvalid !== 1'b1);
        bs_v = bresp;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [31:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge clk_in); while (arready !== 1'b1);
        @(posedge clk_in);
        arvalid <= 1'b0;
        do @(negedge clk_in); while (rvalid !== 1'b1);
        rd_v = rdata_o;
        rs_v = rresp;
        @(posedge clk_in);
    endtask
    task automatic setup(input int ch, input logic [31:0] ctl, s, d, n);
        wr(32'(ch * 16 + 4), s); wr(32'(ch * 16 + 8), d);
        wr(32'(ch * 16 + 12), n); wr(32'(ch * 16), ctl); hcnt = 0;
    endtask
    // Edge trigger, then wait for the expected halt cycles
    task automatic kick(input int ch, input int n);
        trig[ch] <= 1'b1; repeat (5) @(posedge clk_in); trig[ch] <= 1'b0;
        while (hcnt < n) @(posedge clk_in);
        repeat (20) @(posedge clk_in);
    endtask
    task automatic st(input int ch, input logic [2:0] exp);
        rd(32'(ch * 16)); chk(32'(rd_v[12:10]), 32'(exp));
    endtask
    initial
    begin
        for (int k = 0; k < 256; k++) mem_i.mem[k] = 16'hA000 + 16'(k);
        repeat (16) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rd(32'h0000_0030); chk(32'(rs_v), 32'h0000_0002);
        wr(32'h0000_0030, 32'h0000_0000);
        chk(32'(bs_v), 32'h0000_0002);
        setup(0, 32'h0000_0479, 32'h0000_0000, 32'h0000_0100, 32'h0000_0003);
        chk(32'(bs_v), 32'h0000_0000);
        kick(0, 6);
        chm(8'h80, 16'hA000); chm(8'h82, 16'hA002);
        chm(8'h83, 16'hA083); chk(32'(hcnt), 32'h0000_0006);
        st(0, 3'h2); rd(32'h0000_000C); chk(rd_v, 32'h0000_0003);
        setup(1, 32'h0000_04D9, 32'h0000_0004, 32'h0000_0140, 32'h0000_0002);
        kick(1, 4); chm(8'hA0, 16'h0102);
        setup(2, 32'h0000_0511, 32'h0000_0011, 32'h0000_01C2, 32'h0000_0002);
        kick(2, 4); chm(8'hE1, 16'h00A0); chm(8'hE0, 16'h00A0);
        setup(0, 32'h0000_0478, 32'h0000_0020, 32'h0000_0180, 32'h0000_0002);
        kick(0, 2); chm(8'hC1, 16'hA0C1); st(0, 3'h1);
        kick(0, 4); chm(8'hC1, 16'hA011); st(0, 3'h2);
        setup(1, 32'h0000_0479, 32'h0000_0000, 32'h0000_01E0, 32'h0000_0000);
        kick(1, 0); chk(32'(hcnt), 32'h0000_0000);
        setup(0, 32'h0000_047A, 32'h0000_0000, 32'h0000_01A0, 32'h0000_0005);
        kick(0, 10); chk(32'(c1 - c0), 32'h0000_000B);
        chm(8'hD4, 16'hA004); st(0, 3'h2);
        setup(2, 32'h0000_047D, 32'h0000_0000, 32'h0000_01F0, 32'h0000_0001);
        kick(2, 2); chm(8'hF8, 16'hA000); st(2, 3'h3);
        // Level trigger held high runs the block to its end
        setup(0, 32'h0000_0679, 32'h0000_0040, 32'h0000_01B0, 32'h0000_0002);
        trig[0] <= 1'b1;
        repeat (30) @(posedge clk_in);
        trig[0] <= 1'b0;
        chm(8'hD8, 16'hA020);
        chm(8'hD9, 16'hA021);
        chk(32'(hcnt), 32'h0000_0004);
        st(0, 3'h2);
        setup(0, 32'h0000_047C, 32'h0000_0060, 32'h0000_01C8, 32'h0000_0001);
        kick(0, 2);
        st(0, 3'h3);
        kick(0, 4);
        chm(8'hE4, 16'hA030);
        chm(8'hE5, 16'hA031);
        close_out;
    end
endmodule

// file: tb/mcd_mem_model.sv
// Purpose: system bus memory behind the DMA engine
// Assumes: no wait states; read data valid in the rd cycle
// Notes: when not read, data shows the inverse of the last word read
`timescale 1ns/10ps
module mcd_mem_model
(
    input  wire logic                  clk_in,
    input  wire mcd_pkg::mcd_mem_req_t req_in,
    output logic [15:0]                rdata_out
);
    logic [15:0] mem [0:255];
    logic [15:0] last_reg = 16'h0000;
    logic [7:0]  wa;
    logic [7:0]  lane;
    assign wa = req_in.addr[8:1];
    assign lane = req_in.addr[0] ? mem[wa][15:8] : mem[wa][7:0];
    always_comb
    begin
        if (!req_in.rd)
            rdata_out = ~last_reg;
        else if (req_in.byte_unit)
            rdata_out = {8'h00, lane};
        else
            rdata_out = mem[wa];
    end
    always @(posedge clk_in)
    begin
        if (req_in.rd)
            last_reg <= rdata_out;
        if (req_in.wr && !req_in.byte_unit)
            mem[wa] <= req_in.wdata;
        if (req_in.wr && req_in.byte_unit && req_in.addr[0])
            mem[wa][15:8] <= req_in.wdata[7:0];
        if (req_in.wr && req_in.byte_unit && !req_in.addr[0])
            mem[wa][7:0] <= req_in.wdata[7:0];
    end
endmodule
